// ---- rtl/ext_irq_consts.vh ----
// constants for the external pin interrupt unit
`ifndef EXT_IRQ_CONSTS_VH
`define EXT_IRQ_CONSTS_VH
`define ADDR_ENABLE_CTRL 3'h0
`define ADDR_FLAGS       3'h1
`define ADDR_MASK_UPPER  3'h2
`define ADDR_MASK_LOWER  3'h3
`define ADDR_CORE_CTRL   3'h4
`define ADDR_EXT_CTRL    3'h5
`define ADDR_PIN_LEVELS  3'h6
`define BIT_IRQ_ONE      7
`define BIT_IRQ_ZERO     6
`define BIT_IRQ_TWO      5
`define BIT_PC_ONE       4
`define BIT_PC_ZERO      3
`define BIT_VEC_SEL      1
`define BIT_VEC_UNLOCK   0
`define BIT_SENSE_ONE_HI 3
`define BIT_SENSE_ONE_LO 2
`define BIT_SENSE_ZERO_HI 1
`define BIT_SENSE_ZERO_LO 0
`define BIT_SENSE_TWO    0
`define BIT_COMPAT_MODE  7
`define ENABLE_WMASK     8'hfb
`define FLAGS_WMASK      8'hf8
`define CORE_CTRL_WMASK  8'h0f
`define EXT_CTRL_WMASK   8'h81
`define RESET_BYTE       8'h00
`define PIN_SYNC_RESET   2'h3
`define PIN_IDLE_LEVEL   1'b1
`define CORE_CTRL_RESET  4'h0
`define SENSE_LOW        2'h0
`define SENSE_ANY        2'h1
`define SENSE_FALL       2'h2
`define SENSE_RISE       2'h3
`define PULSE_MIN_NS     50
`define CLOCK_PERIOD_NS  8
`define PULSE_MIN_CYCLES ((`PULSE_MIN_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`endif

// ---- rtl/external_pin_interrupt_unit.v ----
// external pin interrupt unit: three dedicated pins, two pin-change groups
//
// The implementer's own choices: strobed register access and the placing of the registers.
`include "ext_irq_consts.vh"
module external_pin_interrupt_unit (
  clock,
  reset,
  address,
  writeData,
  writeStrobe,
  readStrobe,
  readData,
  globalIntEnable,
  irqZeroPin,
  irqOnePin,
  irqTwoPin,
  irqTwoBufferOff,
  pinChangeInputsUpper,
  pinChangeInputsLower,
  irqRequest,
  irqAck,
  vectorTableSelect,
  vectorChangeUnlock
);
  input  wire       clock;
  input  wire       reset;
  input  wire [2:0] address;
  input  wire [7:0] writeData;
  input  wire       writeStrobe;
  input  wire       readStrobe;
  output reg  [7:0] readData;
  input  wire       globalIntEnable;
  input  wire       irqZeroPin;
  input  wire       irqOnePin;
  input  wire       irqTwoPin;
  input  wire       irqTwoBufferOff;
  input  wire [7:0] pinChangeInputsUpper;
  input  wire [7:0] pinChangeInputsLower;
  // bit 4 zero, 3 one, 2 two, 1 group one, 0 group zero
  output wire [4:0] irqRequest;
  input  wire [4:0] irqAck;
  output wire       vectorTableSelect;
  output wire       vectorChangeUnlock;

  reg  [7:0] enableCtrl_r;
  reg  [7:0] flags_r;
  reg  [7:0] maskUpper_r;
  reg  [7:0] maskLower_r;
  reg  [3:0] coreCtrl_r;
  reg        senseTwo_r;
  reg        compatMode_r;
  reg  [7:0] readData_nxt;
  reg  [7:0] flags_nxt;

  // two-flop synchronisers; first stage read only by the second
  reg  [1:0] zeroSync_r;
  reg  [1:0] oneSync_r;
  reg  [1:0] twoSync_r;
  reg  [7:0] upperMeta_r;
  reg  [7:0] upperSync_r;
  reg  [7:0] lowerMeta_r;
  reg  [7:0] lowerSync_r;
  reg        zeroPrev_r;
  reg        onePrev_r;
  reg        twoPrev_r;
  reg  [7:0] upperPrev_r;
  reg  [7:0] lowerPrev_r;

  wire       zeroLevel = zeroSync_r[1];
  wire       oneLevel  = oneSync_r[1];
  // a disabled input buffer reads as low, which can look like an edge
  wire       twoLevel  = twoSync_r[1] & ~irqTwoBufferOff;
  wire [1:0] senseZero = coreCtrl_r[`BIT_SENSE_ZERO_HI:`BIT_SENSE_ZERO_LO];
  wire [1:0] senseOne  = coreCtrl_r[`BIT_SENSE_ONE_HI:`BIT_SENSE_ONE_LO];

  function edge_hit;
    input [1:0] sense;
    input       now;
    input       prev;
    begin
      case (sense)
        `SENSE_ANY:  edge_hit = now ^ prev;
        `SENSE_FALL: edge_hit = prev & ~now;
        `SENSE_RISE: edge_hit = now & ~prev;
        default:     edge_hit = 1'b0;
      endcase
    end
  endfunction

  // pin two has one sense bit: one picks rising, zero picks falling
  function two_edge_hit;
    input sel;
    input now;
    input prev;
    begin
      if (sel) begin
        two_edge_hit = now & ~prev;
      end else begin
        two_edge_hit = prev & ~now;
      end
    end
  endfunction

  // any masked-in pin that toggled since the last clock
  function group_change;
    input       groupEn;
    input [7:0] now;
    input [7:0] prev;
    input [7:0] mask;
    begin
      group_change = groupEn & (|((now ^ prev) & mask));
    end
  endfunction

  // a request needs the core's global flag and its own enable
  function gate_request;
    input globalEn;
    input localEn;
    input pending;
    begin
      gate_request = globalEn & localEn & pending;
    end
  endfunction

  // masks live in extended space, so compat mode reads them as zero
  function [7:0] hide_mask;
    input       active;
    input [7:0] mask;
    begin
      hide_mask = active ? mask : 8'h00;
    end
  endfunction

  wire zeroLevelMode = (senseZero == `SENSE_LOW);
  wire oneLevelMode  = (senseOne == `SENSE_LOW);
  wire zeroEvent = edge_hit(senseZero, zeroLevel, zeroPrev_r);
  wire oneEvent  = edge_hit(senseOne, oneLevel, onePrev_r);
  // pins are sensed whatever their direction, so software can trigger
  wire twoEvent  = two_edge_hit(senseTwo_r, twoLevel, twoPrev_r);
  wire pcActive  = ~compatMode_r;
  wire upperEvent = pcActive &
                    group_change(enableCtrl_r[`BIT_PC_ONE], upperSync_r, upperPrev_r,
                                 maskUpper_r);
  wire lowerEvent = pcActive &
                    group_change(enableCtrl_r[`BIT_PC_ZERO], lowerSync_r, lowerPrev_r,
                                 maskLower_r);

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      zeroSync_r <= `PIN_SYNC_RESET;
      zeroPrev_r <= `PIN_IDLE_LEVEL;
    end else begin
      zeroSync_r <= {zeroSync_r[0], irqZeroPin};
      zeroPrev_r <= zeroLevel;
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      oneSync_r <= `PIN_SYNC_RESET;
      onePrev_r <= `PIN_IDLE_LEVEL;
    end else begin
      oneSync_r <= {oneSync_r[0], irqOnePin};
      onePrev_r <= oneLevel;
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      twoSync_r <= `PIN_SYNC_RESET;
      twoPrev_r <= `PIN_IDLE_LEVEL;
    end else begin
      // a 50 ns pulse spans several 8 ns periods, so sampling cannot miss it
      twoSync_r <= {twoSync_r[0], irqTwoPin};
      twoPrev_r <= twoLevel;
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      upperMeta_r <= `RESET_BYTE;
      upperSync_r <= `RESET_BYTE;
      upperPrev_r <= `RESET_BYTE;
    end else begin
      upperMeta_r <= pinChangeInputsUpper;
      upperSync_r <= upperMeta_r;
      upperPrev_r <= upperSync_r;
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      lowerMeta_r <= `RESET_BYTE;
      lowerSync_r <= `RESET_BYTE;
      lowerPrev_r <= `RESET_BYTE;
    end else begin
      lowerMeta_r <= pinChangeInputsLower;
      lowerSync_r <= lowerMeta_r;
      lowerPrev_r <= lowerSync_r;
    end
  end

  wire flagWrite = writeStrobe & (address == `ADDR_FLAGS);
  wire enableWrite    = writeStrobe & (address == `ADDR_ENABLE_CTRL);
  wire maskUpperWrite = writeStrobe & (address == `ADDR_MASK_UPPER);
  wire maskLowerWrite = writeStrobe & (address == `ADDR_MASK_LOWER);
  wire coreCtrlWrite  = writeStrobe & (address == `ADDR_CORE_CTRL);
  wire extCtrlWrite   = writeStrobe & (address == `ADDR_EXT_CTRL);
  wire [7:0] clearBits = flagWrite ? (writeData & `FLAGS_WMASK) : 8'h00;
  wire [7:0] ackBits = {irqAck[3], irqAck[4], irqAck[2], irqAck[1], irqAck[0], 3'h0};
  wire [7:0] setBits = {oneEvent, zeroEvent, twoEvent, upperEvent, lowerEvent, 3'h0};
  wire [7:0] keptBits = flags_r & ~clearBits & ~ackBits;

  always @* begin
    // set wins over a clear in the same cycle
    flags_nxt = (keptBits | setBits) & `FLAGS_WMASK;
    if (zeroLevelMode) begin
      flags_nxt[`BIT_IRQ_ZERO] = 1'b0;
    end
    if (oneLevelMode) begin
      flags_nxt[`BIT_IRQ_ONE] = 1'b0;
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      flags_r <= `RESET_BYTE;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      enableCtrl_r <= `RESET_BYTE;
    end else if (enableWrite) begin
      enableCtrl_r <= writeData & `ENABLE_WMASK;
    end
  end

  // mask writes are dropped while compat mode hides the masks
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      maskUpper_r <= `RESET_BYTE;
    end else if (maskUpperWrite && pcActive) begin
      maskUpper_r <= writeData;
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      maskLower_r <= `RESET_BYTE;
    end else if (maskLowerWrite && pcActive) begin
      maskLower_r <= writeData;
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      coreCtrl_r <= `CORE_CTRL_RESET;
    end else if (coreCtrlWrite) begin
      coreCtrl_r <= writeData[3:0];
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      senseTwo_r   <= 1'b0;
      compatMode_r <= 1'b0;
    end else if (extCtrlWrite) begin
      senseTwo_r   <= writeData[`BIT_SENSE_TWO];
      compatMode_r <= writeData[`BIT_COMPAT_MODE];
    end
  end

  always @* begin
    readData_nxt = 8'h00;
    case (address)
      `ADDR_ENABLE_CTRL: readData_nxt = enableCtrl_r;
      `ADDR_FLAGS:       readData_nxt = flags_r;
      `ADDR_MASK_UPPER:  readData_nxt = hide_mask(pcActive, maskUpper_r);
      `ADDR_MASK_LOWER:  readData_nxt = hide_mask(pcActive, maskLower_r);
      `ADDR_CORE_CTRL:   readData_nxt = {4'h0, coreCtrl_r};
      `ADDR_EXT_CTRL:    readData_nxt = {compatMode_r, 6'h00, senseTwo_r};
      `ADDR_PIN_LEVELS:  readData_nxt = {5'h00, twoLevel, oneLevel, zeroLevel};
      default:           readData_nxt = 8'h00;
    endcase
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      readData <= 8'h00;
    end else if (readStrobe) begin
      readData <= readData_nxt;
    end else begin
      readData <= 8'h00;
    end
  end

  // level mode asks for service while the pin stays low
  wire zeroPending = zeroLevelMode ? ~zeroLevel : flags_r[`BIT_IRQ_ZERO];
  wire onePending  = oneLevelMode ? ~oneLevel : flags_r[`BIT_IRQ_ONE];

  assign irqRequest[4] = gate_request(globalIntEnable, enableCtrl_r[`BIT_IRQ_ZERO],
                                      zeroPending);
  assign irqRequest[3] = gate_request(globalIntEnable, enableCtrl_r[`BIT_IRQ_ONE],
                                      onePending);
  assign irqRequest[2] = gate_request(globalIntEnable, enableCtrl_r[`BIT_IRQ_TWO],
                                      flags_r[`BIT_IRQ_TWO]);
  // pin-change requests also vanish while compat mode hides the masks
  assign irqRequest[1] = gate_request(globalIntEnable, enableCtrl_r[`BIT_PC_ONE],
                                      flags_r[`BIT_PC_ONE] & pcActive);
  assign irqRequest[0] = gate_request(globalIntEnable, enableCtrl_r[`BIT_PC_ZERO],
                                      flags_r[`BIT_PC_ZERO] & pcActive);
  assign vectorTableSelect  = enableCtrl_r[`BIT_VEC_SEL];
  assign vectorChangeUnlock = enableCtrl_r[`BIT_VEC_UNLOCK];
endmodule // external_pin_interrupt_unit

// ---- dv/ext_irq_chk_sva.sv ----
// assertion checker for the external pin interrupt unit
module ext_irq_chk (
  input wire logic       clock,
  input wire logic       reset,
  input wire logic [2:0] address,
  input wire logic [7:0] writeData,
  input wire logic       writeStrobe,
  input wire logic       readStrobe,
  input wire logic [7:0] readData,
  input wire logic       globalIntEnable,
  input wire logic       irqZeroPin,
  input wire logic       irqTwoPin,
  input wire logic [4:0] irqRequest
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] en_r;
  logic [7:0] sns_r;
  logic       ext_r;
  // shadows rebuilt from bus writes, since the checker sees ports only
  always_ff @(posedge clock or posedge reset)
    if (reset) en_r <= 8'h00;
    else if (writeStrobe && address == 3'h0) en_r <= writeData;
  always_ff @(posedge clock or posedge reset)
    if (reset) sns_r <= 8'h00;
    else if (writeStrobe && address == 3'h4) sns_r <= writeData;
  always_ff @(posedge clock or posedge reset)
    if (reset) ext_r <= 1'b0;
    else if (writeStrobe && address == 3'h5) ext_r <= writeData[0];
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  a_vec_enable: assert property ((irqRequest & ~{en_r[6], en_r[7], en_r[5:3]}) == 5'h00)
    else $error("request without its enable");
  a_gie_gate: assert property (!globalIntEnable |-> irqRequest == 5'h00)
    else $error("request without global flag");
  a_enable_bit2: assert property ($past(readStrobe) && $past(address) == 3'h0 |-> !readData[2])
    else $error("enable bit 2 not zero");
  a_flag_low: assert property ($past(readStrobe) && $past(address) == 3'h1 |->
    readData[2:0] == 3'h0)
    else $error("flag low bits not zero");
  a_level_flag: assert property ($past(readStrobe) && $past(address) == 3'h1 &&
    $past(sns_r[1:0]) == 2'h0 |-> !readData[6]) else $error("level mode flag set");
  a_level_req: assert property ((!irqZeroPin)[*3] ##0 (sns_r[1:0] == 2'h0 && en_r[6] &&
    globalIntEnable) |-> irqRequest[4]) else $error("low level not requesting");
  a_fall_zero: assert property ($fell(irqZeroPin) && sns_r[1:0] == 2'h2 && en_r[6] &&
    globalIntEnable |-> ##[1:4] irqRequest[4]) else $error("falling edge missed");
  a_rise_two: assert property ($rose(irqTwoPin) && ext_r && en_r[5] && globalIntEnable
    |-> ##[1:4] irqRequest[2]) else $error("pin two rise missed");
  c_level: cover property (irqRequest[4] && sns_r[1:0] == 2'h0);
  c_group: cover property (irqRequest[1:0] != 2'h0);
  c_two: cover property (irqRequest[2]);
endmodule // ext_irq_chk

bind external_pin_interrupt_unit ext_irq_chk ext_irq_chk_inst (.clock, .reset, .address,
  .writeData, .writeStrobe, .readStrobe, .readData, .globalIntEnable, .irqZeroPin,
  .irqTwoPin, .irqRequest);

// ---- dv/cpu_dispatch_model.sv ----
// cpu side model: enters one pending handler at a time
module cpu_dispatch_model (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       acceptOn,
  input  wire logic [4:0] irqRequest,
  output logic      [4:0] irqAck
);
  timeunit 1ns;
  timeprecision 1ps;
  // lowest pending vector first; acceptOn low models a busy core
  always_ff @(posedge clock or posedge reset)
    if (reset) irqAck <= 5'h00;
    else irqAck <= (acceptOn && irqAck == 5'h00) ? irqRequest & (~irqRequest + 5'h01) : 5'h00;
endmodule // cpu_dispatch_model

// ---- dv/testbench.sv ----
// self-checking bench for the external pin interrupt unit
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock = 1'b0;
  logic       reset = 1'b1;
  logic [2:0] address = 3'h0;
  logic [7:0] writeData = 8'h00;
  logic       writeStrobe = 1'b0;
  logic       readStrobe = 1'b0;
  logic       globalIntEnable = 1'b0;
  logic       irqZeroPin = 1'b1;
  logic       irqOnePin = 1'b1;
  logic       irqTwoPin = 1'b1;
  logic [7:0] pinChangeInputsUpper = 8'h00;
  logic [7:0] pinChangeInputsLower = 8'h00;
  logic       acceptOn = 1'b0;
  logic       bufferOff = 1'b0;
  logic       vecSel;
  logic       vecUnlock;
  logic       rdLast = 1'b0;
  logic [7:0] readData;
  logic [7:0] m;
  logic [4:0] irqRequest;
  logic [4:0] irqAck;
  logic [7:0] expQ[$];
  int         errors = 0;
  int         samplesChecked = 0;

  always #4 clock = ~clock;

  external_pin_interrupt_unit external_pin_interrupt_unit_inst (.clock, .reset, .address,
    .writeData, .writeStrobe, .readStrobe, .readData, .globalIntEnable, .irqZeroPin,
    .irqOnePin, .irqTwoPin, .irqTwoBufferOff(bufferOff), .pinChangeInputsUpper,
    .pinChangeInputsLower, .irqRequest, .irqAck, .vectorTableSelect(vecSel),
    .vectorChangeUnlock(vecUnlock));
  cpu_dispatch_model cpu_dispatch_model_inst (.clock, .reset, .acceptOn, .irqRequest, .irqAck);

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", samplesChecked, errors);
    if (errors == 0 && samplesChecked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // a gap cycle after each strobe keeps one assignment per signal per step
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    address <= a;
    writeData <= d;
    writeStrobe <= 1'b1;
    @(posedge clock);
    writeStrobe <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    address <= a;
    readStrobe <= 1'b1;
    expQ.push_back(e);
    @(posedge clock);
    readStrobe <= 1'b0;
    @(posedge clock);
  endtask
  task automatic waitReq(input int b);
    int n;
    n = 0;
    while (irqRequest[b] !== 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    check({7'h00, irqRequest[b]}, 8'h01);
    if (irqRequest[b] !== 1'b1) report_and_stop();
    @(posedge clock);
  endtask
  // pin two stays disabled while sense bits change
  task automatic fire(input logic lvl, input logic [2:0] e);
    wr(3'h1, 8'hff);
    wr(3'h0, 8'hfb);
    irqZeroPin <= lvl;
    irqOnePin <= lvl;
    irqTwoPin <= lvl;
    repeat (5) @(posedge clock);
    rd(3'h1, {e, 5'h00});
    wr(3'h0, 8'hdb);
  endtask

  always @(posedge clock) begin
    if (rdLast && expQ.size() > 0)
      check(readData, expQ.pop_front());
    rdLast <= readStrobe;
  end

  initial begin
    void'($urandom(32'h362d));
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    for (int a = 0; a < 6; a++) rd(a[2:0], 8'h00);
    rd(3'h7, 8'h00);
    rd(3'h6, 8'h07);
    globalIntEnable <= 1'b1;
    wr(3'h0, 8'hff);
    check({6'h00, vecSel, vecUnlock}, 8'h03);
    rd(3'h0, 8'hfb);
    $display("test registers done");
    for (int g = 0; g < 2; g++) begin
      m = 8'h01 << $urandom_range(7);
      wr(g ? 3'h2 : 3'h3, m);
      rd(g ? 3'h2 : 3'h3, m);
      if (g) pinChangeInputsUpper <= pinChangeInputsUpper ^ ~m;
      else pinChangeInputsLower <= pinChangeInputsLower ^ ~m;
      repeat (6) @(negedge clock);
      check({6'h00, irqRequest[1:0]}, 8'h00);
      @(posedge clock);
      if (g) pinChangeInputsUpper <= pinChangeInputsUpper ^ m;
      else pinChangeInputsLower <= pinChangeInputsLower ^ m;
      waitReq(g);
      rd(3'h1, g ? 8'h10 : 8'h08);
      wr(3'h1, 8'hff);
      rd(3'h1, 8'h00);
    end
    $display("test pin change done");
    wr(3'h0, 8'hdb);
    for (int s = 1; s < 4; s++) begin
      wr(3'h4, {4'h0, s[1:0], s[1:0]});
      wr(3'h5, {7'h00, s[0]});
      fire(1'b0, {s != 3, s != 3, s == 2});
      fire(1'b1, {s != 2, s != 2, s != 2});
    end
    $display("test edges done");
    wr(3'h1, 8'h20);
    wr(3'h4, 8'h00);
    wr(3'h0, 8'hc0);
    irqZeroPin <= 1'b0;
    waitReq(4);
    rd(3'h1, 8'h00);
    globalIntEnable <= 1'b0;
    @(negedge clock);
    check({3'h0, irqRequest}, 8'h00);
    @(posedge clock);
    globalIntEnable <= 1'b1;
    irqZeroPin <= 1'b1;
    wr(3'h4, 8'h0a);
    acceptOn <= 1'b1;
    irqZeroPin <= 1'b0;
    irqOnePin <= 1'b0;
    repeat (8) @(posedge clock);
    rd(3'h1, 8'h00);
    $display("test level and ack done");
    wr(3'h5, 8'h80);
    bufferOff <= 1'b1;
    repeat (4) @(posedge clock);
    rd(3'h1, 8'h20);
    bufferOff <= 1'b0;
    wr(3'h2, 8'hff);
    rd(3'h2, 8'h00);
    $display("test compat done");
    report_and_stop();
  end
endmodule // testbench
